// File: hw/mtrt_request_term.sv
// termination, byte handshake and token class for transmit requests
`timescale 1ns/1ps
`include "mtrt_params.svh"

////////////////////////////////////////////////////////////////////////
// saturating qualification counter, cleared when its condition drops
module mtrt_qual_counter
    import mtrt_pkg::*;
#(
    parameter int CNT_W = 2
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // condition being qualified
    input wire logic cond_in,
    // byte times the condition has stood
    output logic [CNT_W-1:0] count_out
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    // saturate so a long wait never wraps back below the threshold
    always_comb begin
        count_nxt = count_r;
        if (!cond_in) begin
            count_nxt = '0;
        end else if (count_r != CNT_MAX) begin
            count_nxt = count_r + CNT_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count_out = count_r;
endmodule

////////////////////////////////////////////////////////////////////////
// request termination, byte acceptance and token class
module mtrt_request_term
    import mtrt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // request side
    input wire mtrt_req_t req_in,
    input wire mtrt_byte_t byte_in,
    // transmitter status
    input wire mtrt_tx_status_t tx_status_in,
    // outputs
    output logic transmit_byte_acceptance_out,
    output logic current_token_class_out,
    output logic [7:0] tx_byte_out,
    output logic tx_byte_valid_out,
    output logic tx_last_out,
    output mtrt_abort_kind_t abort_kind_out,
    output logic final_accepted_out
);
    ////////////////////////////////////////////////////////////////////
    localparam int CNT_W = 2;

    // qualification counts
    logic [CNT_W-1:0] ready_cnt;
    logic [CNT_W-1:0] param_cnt;

    // decoded request events
    logic final_ok;
    logic eof_take;
    logic abort_take;
    logic start_take;
    logic stop_status;
    logic byte_take;

    // registered state and next values
    logic accept_r;
    logic accept_nxt;
    logic class_r;
    logic class_nxt;
    logic final_acc_r;
    logic final_acc_nxt;
    logic [7:0] tx_byte_r;
    logic [7:0] tx_byte_nxt;
    logic tx_valid_r;
    logic tx_valid_nxt;
    logic tx_last_r;
    logic tx_last_nxt;
    mtrt_abort_kind_t abort_kind_r;
    mtrt_abort_kind_t abort_kind_nxt;

    ////////////////////////////////////////////////////////////////////
    // qualification counters
    mtrt_qual_counter #(
        .CNT_W(CNT_W)
    ) i_ready_qual (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cond_in(req_in.request_ready),
        .count_out(ready_cnt)
    );

    mtrt_qual_counter #(
        .CNT_W(CNT_W)
    ) i_param_qual (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .cond_in(req_in.params_valid),
        .count_out(param_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // request event decode
    assign final_ok = req_in.final_frame_indication
        && req_in.request_ready
        && !req_in.request_send
        && (ready_cnt >= `MTRT_READY_BYTES)
        && (param_cnt >= `MTRT_PARAM_BYTES);

    // eof only counts while acceptance is up
    assign eof_take = byte_in.end_of_frame_marker && accept_r;
    assign abort_take = byte_in.abort_request && !byte_in.end_of_frame_marker;
    assign start_take = byte_in.first_byte && req_in.request_send;
    assign stop_status = tx_status_in.transmit_aborted_indication
        || tx_status_in.transmit_pass_indication;
    assign byte_take = accept_r || start_take;

    ////////////////////////////////////////////////////////////////////
    // token class
    always_comb begin
        class_nxt = class_r;
        if (final_ok) begin
            class_nxt = `MTRT_CLASS_ISSUE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            class_r <= `MTRT_CLASS_CAPTURE;
        end else begin
            class_r <= class_nxt;
        end
    end

    // one pulse per byte time in which final is taken
    always_comb begin
        final_acc_nxt = final_ok;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            final_acc_r <= 1'b0;
        end else begin
            final_acc_r <= final_acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // byte acceptance handshake; abort outranks everything but eof
    always_comb begin
        accept_nxt = accept_r;
        if (abort_take) begin
            accept_nxt = 1'b0;
        end else if (eof_take) begin
            accept_nxt = 1'b0;
        end else if (stop_status) begin
            accept_nxt = 1'b0;
        end else if (start_take) begin
            accept_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            accept_r <= 1'b0;
        end else begin
            accept_r <= accept_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // byte path to the transmitter
    always_comb begin
        tx_byte_nxt = byte_in.data;
        tx_valid_nxt = byte_take && !abort_take;
        tx_last_nxt = eof_take;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_byte_r <= 8'h00;
            tx_valid_r <= 1'b0;
            tx_last_r <= 1'b0;
        end else begin
            tx_byte_r <= tx_byte_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_last_r <= tx_last_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // abort substitutes a void, claim or beacon frame
    always_comb begin
        abort_kind_nxt = MTRT_ABORT_NONE;
        if (abort_take && accept_r) begin
            if (tx_status_in.in_beacon) begin
                abort_kind_nxt = MTRT_ABORT_BEACON;
            end else if (tx_status_in.in_claim) begin
                abort_kind_nxt = MTRT_ABORT_CLAIM;
            end else begin
                abort_kind_nxt = MTRT_ABORT_VOID;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            abort_kind_r <= MTRT_ABORT_NONE;
        end else begin
            abort_kind_r <= abort_kind_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, each straight from its register
    assign transmit_byte_acceptance_out = accept_r;
    assign current_token_class_out = class_r;
    assign final_accepted_out = final_acc_r;
    assign tx_byte_out = tx_byte_r;
    assign tx_byte_valid_out = tx_valid_r;
    assign tx_last_out = tx_last_r;
    assign abort_kind_out = abort_kind_r;
endmodule

// File: hw/mtrt_params.svh
// constants for the transmit request termination block
// What this block does
// - accepted final frame switches to issue class
// - final ignored unless ready held one byte
// - final ignored unless parameters valid three bytes
// - end of frame drops byte acceptance
// - end of frame ignored without byte acceptance
// - abort makes transmitter send void/claim/beacon frame
// - abort drops byte acceptance
// - acceptance from control byte, drops after end
// - no byte acceptance while abort is asserted without end of frame
// - abort together with end of frame ignored
`ifndef MTRT_PARAMS_SVH
`define MTRT_PARAMS_SVH
`define MTRT_READY_BYTES 2'h1
`define MTRT_PARAM_BYTES 2'h3
`define MTRT_CLASS_CAPTURE 1'h0
`define MTRT_CLASS_ISSUE 1'h1
`endif

// File: hw/mtrt_pkg.sv
// types for the transmit request termination block
package mtrt_pkg;
    typedef enum logic [1:0] {
        MTRT_ABORT_NONE,
        MTRT_ABORT_VOID,
        MTRT_ABORT_CLAIM,
        MTRT_ABORT_BEACON
    } mtrt_abort_kind_t;
    typedef struct packed {
        logic request_ready;
        logic request_send;
        logic params_valid;
        logic final_frame_indication;
    } mtrt_req_t;
    typedef struct packed {
        logic [7:0] data;
        logic first_byte;
        logic end_of_frame_marker;
        logic abort_request;
    } mtrt_byte_t;
    typedef struct packed {
        logic transmit_aborted_indication;
        logic transmit_pass_indication;
        logic in_claim;
        logic in_beacon;
    } mtrt_tx_status_t;
endpackage

// File: tb/mtrt_requester.sv
// requester model for the request side
`timescale 1ns/1ps
module mtrt_requester
    import mtrt_pkg::*;
(
    // commands in, request side out
    input wire mtrt_req_t cmd_req_in,
    input wire mtrt_byte_t cmd_byte_in,
    output mtrt_req_t req_out,
    output mtrt_byte_t byte_out
);
    always_comb begin
        req_out = cmd_req_in;
        req_out.final_frame_indication &= cmd_req_in.request_ready & ~cmd_req_in.request_send;
        byte_out = cmd_byte_in;
        // idle bus shows inverted data
        if (!cmd_req_in.request_send) begin
            byte_out.data = ~cmd_byte_in.data;
        end
    end
endmodule

// File: tb/mtrt_request_term_properties.sv
// port assertions for the request termination block
`timescale 1ns/1ps
module mtrt_request_term_properties
    import mtrt_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire mtrt_req_t req_in,
    input wire mtrt_byte_t byte_in,
    input wire logic transmit_byte_acceptance_out,
    input wire logic current_token_class_out,
    input wire logic tx_last_out,
    input wire mtrt_abort_kind_t abort_kind_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic acc = transmit_byte_acceptance_out;
    wire logic eof = byte_in.end_of_frame_marker;
    wire logic abt = byte_in.abort_request;
    sequence s_abort;
        acc && abt && !eof;
    endsequence
    start_accept_a: assert property (byte_in.first_byte && req_in.request_send && !abt |=> acc)
        else $error("acceptance missing");
    eof_drop_a: assert property (acc && eof |=> !acc && tx_last_out) else $error("eof drop");
    eof_ignore_a: assert property (!acc |=> !tx_last_out) else $error("eof taken");
    abort_drop_a: assert property (s_abort |=> !acc) else $error("abort drop");
    abort_block_a: assert property (abt |=> !acc) else $error("abort block");
    abort_frame_a: assert property (s_abort |=> abort_kind_out != MTRT_ABORT_NONE)
        else $error("abort frame");
    abort_eof_a: assert property (acc && abt && eof |=> abort_kind_out == MTRT_ABORT_NONE)
        else $error("abort with eof");
    class_hold_a: assert property (current_token_class_out |=> current_token_class_out)
        else $error("class lost");
endmodule
bind mtrt_request_term mtrt_request_term_properties i_props (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .req_in(req_in), .byte_in(byte_in), .tx_last_out(tx_last_out),
    .transmit_byte_acceptance_out(transmit_byte_acceptance_out),
    .current_token_class_out(current_token_class_out), .abort_kind_out(abort_kind_out));

// File: tb/mtrt_request_term_bench.sv
// self-checking bench for the request termination block
`timescale 1ns/1ps
module mtrt_request_term_bench;
    import mtrt_pkg::*;
    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    mtrt_req_t cr = 4'h4;
    mtrt_byte_t cb = 11'h000;
    mtrt_tx_status_t st = 4'h0;
    mtrt_req_t rq;
    mtrt_byte_t bq;
    logic acc, cls, ea, fa, tl, tv, ev;
    logic pa = 1'h0;
    logic [7:0] tb;
    logic [1:0] ek;
    mtrt_abort_kind_t kd;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // byte, status, expected acceptance, expected abort kind
    logic [17:0] rows [15] = '{18'h04204, 18'h08004, 18'h0C100, 18'h10100, 18'h14204,
        18'h1808B, 18'h1C204, 18'h20092, 18'h24204, 18'h28081, 18'h2C204, 18'h30180,
        18'h34280, 18'h38204, 18'h00020};
    mtrt_requester i_mtrt_requester (.cmd_req_in(cr), .cmd_byte_in(cb), .req_out(rq),
        .byte_out(bq));
    mtrt_request_term i_mtrt_request_term (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_in(rq), .byte_in(bq), .tx_status_in(st), .transmit_byte_acceptance_out(acc),
        .current_token_class_out(cls), .tx_byte_out(tb), .tx_byte_valid_out(tv),
        .tx_last_out(tl), .abort_kind_out(kd), .final_accepted_out(fa));
    initial forever #2.5 clk_in = ~clk_in;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'h0;
        chk("reset acceptance", 3'h0, 3'(acc));
        foreach (rows[i]) begin
            {cb, st, ea, ek} = rows[i];
            @(negedge clk_in);
            chk("acceptance", 3'(ea), 3'(acc));
            chk("abort kind", 3'(ek), 3'(kd));
            ev = (pa | cb.first_byte) & ~(cb.abort_request & ~cb.end_of_frame_marker);
            chk("tx byte", cb.data, tb);
            chk("tx last", 8'(cb.end_of_frame_marker & pa), 8'(tl));
            chk("tx valid", 8'(ev), 8'(tv));
            pa = ea;
        end
        {cb, st} = 15'h0000;
        // ready, params and final together: params count decides
        cr = 4'hB;
        repeat (3) @(negedge clk_in);
        chk("class early", 3'h0, 3'(cls));
        chk("final early", 8'h00, 8'(fa));
        @(negedge clk_in);
        chk("class issued", 3'h1, 3'(cls));
        chk("final pulse", 8'h01, 8'(fa));
        sys_rst_in = 1'h1;
        cr = 4'h2;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'h0;
        chk("class reset", 3'h0, 3'(cls));
        repeat (4) @(negedge clk_in);
        cr = 4'hB;
        @(negedge clk_in);
        chk("class ready", 3'h0, 3'(cls));
        chk("final ready", 8'h00, 8'(fa));
        @(negedge clk_in);
        chk("class ready", 3'h1, 3'(cls));
        chk("final taken", 8'h01, 8'(fa));
        give_verdict();
    end
endmodule
